/* src/wwg_core.sv */
// Windowed watchdog core: key sequences, tally, window checks, events and register port
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "wwg_defs.svh"

module wwg_core (
    // Clock and power-on reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // System reset in progress, level from the reset controller on mclk
    input  wire logic        sysResetActive,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic [31:0]      rdData,
    // Watchdog outputs
    output logic             wdtIrq,
    output logic             sysRstReq
);

    // Registered state and its next copy
    wwg_pkg::wwg_state_t st;
    wwg_pkg::wwg_state_t next_st;
    // Bus request bundle
    wwg_pkg::wwg_bus_t   bus;
    // Tick enable from the divider
    logic                tickEn;
    // Decoded thresholds in tick counts
    logic [31:0]         thrIntLate;
    logic [31:0]         thrRstLate;
    logic [31:0]         thrIntEarly;
    logic [31:0]         thrRstEarly;
    // Register port decode
    logic                wrCtrl;
    logic                wrKey;
    logic                wrSrc;
    // Key actions, one cycle each
    logic                doFeed;
    logic                doStart;
    logic                doStop;
    // Tick side service strobes
    logic                serveFeed;
    logic                serveRun;
    // Hardware event strobes
    logic                evIntEarly;
    logic                evRstEarly;
    logic                evIntLate;
    logic                evRstLate;
    // Incremented tally
    logic [31:0]         countInc;
    // Clock ready status
    logic                clkRdy;

    // Code n stands for two to the power 31 minus n ticks
    // A shift keeps the decode to one stage instead of a sixteen-entry table
    function automatic logic [31:0] thrDecode(input logic [3:0] code);
        logic [4:0] expo;
        expo = `WWG_THR_TOP_EXP - {1'b0, code};
        return 32'h0000_0001 << expo;
    endfunction

    // Tick enable for the tally
    wwg_tick_divider u_div (
        .mclk    (mclk),
        .nrst    (nrst),
        .tickSel (st.tickSel),
        .tickEn  (tickEn)
    );

    // Gather the port into one bundle
    always_comb begin
        bus.addr   = addr;
        bus.wrData = wrData;
        bus.wrStb  = wrStb;
        bus.rdStb  = rdStb;
    end

    // Thresholds follow the programmed codes
    always_comb begin
        thrIntLate  = thrDecode(st.intLateVal);
        thrRstLate  = thrDecode(st.rstLateVal);
        thrIntEarly = thrDecode(st.intEarlyVal);
        thrRstEarly = thrDecode(st.rstEarlyVal);
    end

    // Address decode of writes
    always_comb begin
        wrCtrl = bus.wrStb && (bus.addr == `WWG_OFS_CONTROL);
        wrKey  = bus.wrStb && (bus.addr == `WWG_OFS_KEY);
        wrSrc  = bus.wrStb && (bus.addr == `WWG_OFS_SOURCE);
    end

    // Second key completes a pair only when it matches the pending first
    always_comb begin
        doFeed  = wrKey && (st.keyState == wwg_pkg::KEY_FEED1)
                  && (bus.wrData[7:0] == `WWG_KEY_FEED_B);
        doStart = wrKey && (st.keyState == wwg_pkg::KEY_START1)
                  && (bus.wrData[7:0] == `WWG_KEY_START_B);
        doStop  = wrKey && (st.keyState == wwg_pkg::KEY_STOP1)
                  && (bus.wrData[7:0] == `WWG_KEY_STOP_B);
    end

    // Tick side takes a feed on a tick, or at once while stopped
    // Stopped means no tally step to collide with, so no wait is needed
    always_comb begin
        serveFeed = st.feedPend && (tickEn || !st.runLive);
        serveRun  = (st.runLive != st.runBit) && tickEn;
        countInc  = st.count + 32'h0000_0001;
    end

    // Window checks at the moment a feed is applied, late checks on each tick
    // Early checks see the tally before the feed clears it
    // Late checks compare the stepped value, so each threshold fires on one tick only
    always_comb begin
        evRstEarly = serveFeed && st.runLive && (st.count < thrRstEarly);
        evIntEarly = serveFeed && st.runLive && (st.count >= thrRstEarly)
                     && (st.count < thrIntEarly);
        evIntLate  = st.runLive && tickEn && !serveFeed
                     && (countInc == thrIntLate);
        evRstLate  = st.runLive && tickEn && !serveFeed
                     && (countInc == thrRstLate);
    end

    // Ready once the tick side has caught up with the run bit
    // A run change undone before the next tick reads ready again at once
    assign clkRdy = (st.runLive == st.runBit);

    // Next state of the whole core
    always_comb begin
        next_st = st;

        // Key sequencer; any other write breaks a feed pair in progress
        if (wrKey) begin
            // Last byte kept for readback whatever its value
            next_st.keyLast = bus.wrData[7:0];
            case (bus.wrData[7:0])
                `WWG_KEY_FEED_A:  next_st.keyState = wwg_pkg::KEY_FEED1;
                `WWG_KEY_START_A: next_st.keyState = wwg_pkg::KEY_START1;
                `WWG_KEY_STOP_A:  next_st.keyState = wwg_pkg::KEY_STOP1;
                default:          next_st.keyState = wwg_pkg::KEY_IDLE;
            endcase
        end else if (bus.wrStb && (st.keyState == wwg_pkg::KEY_FEED1)) begin
            // Feed halves must not be split by another write on the port
            next_st.keyState = wwg_pkg::KEY_IDLE;
        end
        // Start and stop halves wait any length of time
        if (doFeed || doStart || doStop) begin
            next_st.keyState = wwg_pkg::KEY_IDLE;
        end

        // Software writes of the control word
        if (wrCtrl) begin
            next_st.rstLate     = bus.wrData[`WWG_POS_RST_LATE];
            next_st.rstEarly    = bus.wrData[`WWG_POS_RST_EARLY];
            next_st.winEn       = bus.wrData[`WWG_POS_WIN_EN];
            next_st.clkRdyIe    = bus.wrData[`WWG_POS_RDY_IE];
            next_st.rstEarlyVal = bus.wrData[`WWG_POS_RST_EVAL +: 4];
            next_st.intEarlyVal = bus.wrData[`WWG_POS_INT_EVAL +: 4];
            next_st.intEarly    = bus.wrData[`WWG_POS_INT_EARLY];
            next_st.rstEn       = bus.wrData[`WWG_POS_RST_EN];
            next_st.intEn       = bus.wrData[`WWG_POS_INT_EN];
            next_st.intLate     = bus.wrData[`WWG_POS_INT_LATE];
            next_st.runBit      = bus.wrData[`WWG_POS_RUN];
            next_st.rstLateVal  = bus.wrData[`WWG_POS_RST_LVAL +: 4];
            next_st.intLateVal  = bus.wrData[`WWG_POS_INT_LVAL +: 4];
        end

        // Source change only while stopped, so the tick rate never jumps mid-count
        // Limitation: a write while running is dropped with no error flag
        if (wrSrc && !st.runBit && !st.runLive) begin
            next_st.tickSel = bus.wrData[2:0];
        end

        // Key pairs steer the run bit, overriding a plain write
        // Both pairs fall on key writes, so they never meet a control write
        if (doStart) begin
            next_st.runBit = 1'b1;
        end
        if (doStop) begin
            next_st.runBit = 1'b0;
        end

        // Feed request handed to the tick side; a new one wins over the serve
        // The pending bit is the handshake: set here, cleared when served
        if (serveFeed) begin
            next_st.feedPend = 1'b0;
        end
        if (doFeed) begin
            next_st.feedPend = 1'b1;
        end

        // Tick side follows the run bit one tick later
        if (serveRun) begin
            next_st.runLive = st.runBit;
        end

        // Tally: cleared by a feed, otherwise one step per tick while running
        // Clear wins over the step, so a fed tally never starts at one
        if (serveFeed) begin
            next_st.count = `WWG_RST_TALLY;
        end else if (st.runLive && tickEn) begin
            next_st.count = countInc;
        end

        // Flags set whatever the enables say; a set wins over a software clear
        if (evIntEarly) begin
            next_st.intEarly = 1'b1;
        end
        if (evRstEarly) begin
            next_st.rstEarly = 1'b1;
        end
        if (evIntLate) begin
            next_st.intLate = 1'b1;
        end
        if (evRstLate) begin
            next_st.rstLate = 1'b1;
        end

        // Reset request, early ones only with the window on
        // Registered, so the reset controller sees one clean pulse per event
        next_st.sysRstReq = (st.rstEn && evRstLate)
                            || (st.rstEn && st.winEn && evRstEarly);

        // Read data stand the cycle after the read strobe only
        // Zero outside a read keeps stale values off a shared read bus
        next_st.rdData = 32'h0000_0000;
        if (bus.rdStb) begin
            case (bus.addr)
                `WWG_OFS_CONTROL: next_st.rdData = {st.rstLate, st.rstEarly, st.winEn, clkRdy,
                                                    st.clkRdyIe, 3'h0, st.rstEarlyVal,
                                                    st.intEarlyVal, 3'h0, st.intEarly, st.rstEn,
                                                    st.intEn, st.intLate, st.runBit,
                                                    st.rstLateVal, st.intLateVal};
                `WWG_OFS_KEY:     next_st.rdData = {24'h00_0000, st.keyLast};
                `WWG_OFS_SOURCE:  next_st.rdData = {29'h0000_0000, st.tickSel};
                `WWG_OFS_TALLY:   next_st.rdData = st.count;
                default:          next_st.rdData = 32'h0000_0000;
            endcase
        end

        // System reset zeroes the tally and settings, but run and flags survive
        // Key state, last key and tick source ride through too; only power-on clears them
        if (sysResetActive) begin
            next_st.count       = `WWG_RST_TALLY;
            next_st.winEn       = 1'b0;
            next_st.clkRdyIe    = 1'b0;
            next_st.rstEarlyVal = `WWG_RST_CODE;
            next_st.intEarlyVal = `WWG_RST_CODE;
            next_st.rstEn       = 1'b0;
            next_st.intEn       = 1'b0;
            next_st.rstLateVal  = `WWG_RST_CODE;
            next_st.intLateVal  = `WWG_RST_CODE;
            next_st.feedPend    = 1'b0;
            next_st.sysRstReq   = 1'b0;
        end
    end

    // Register the whole core; power-on reset clears everything
    // Field resets spelled out so the power-on view of each field is plain
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st          <= '0;
            st.keyState <= wwg_pkg::KEY_IDLE;
            st.keyLast  <= `WWG_RST_KEY;
            st.tickSel  <= `WWG_RST_SOURCE;
            st.count    <= `WWG_RST_TALLY;
        end else begin
            st <= next_st;
        end
    end

    // Interrupt: both windows under one enable, ready under its own gate
    // A level, not a pulse: it stays up until the flag or the enable is cleared
    always_comb begin
        wdtIrq = (st.intEn && (st.intLate || (st.winEn && st.intEarly)))
                 || (st.clkRdyIe && clkRdy);
    end

    // Data outputs straight from flops
    // No logic after the flops, so the outputs carry no glitches
    assign rdData    = st.rdData;
    assign sysRstReq = st.sysRstReq;

endmodule

`default_nettype wire

/* src/wwg_defs.svh */
// Register offsets, field positions, key values and reset values of the windowed watchdog
`ifndef WWG_DEFS_SVH
`define WWG_DEFS_SVH

// Byte offsets on the register port
`define WWG_OFS_CONTROL     8'h00
`define WWG_OFS_KEY         8'h04
`define WWG_OFS_SOURCE      8'h08
`define WWG_OFS_TALLY       8'h0c

// Control word field positions
`define WWG_POS_RST_LATE    31
`define WWG_POS_RST_EARLY   30
`define WWG_POS_WIN_EN      29
`define WWG_POS_CLK_RDY     28
`define WWG_POS_RDY_IE      27
`define WWG_POS_RST_EVAL    20
`define WWG_POS_INT_EVAL    16
`define WWG_POS_INT_EARLY   12
`define WWG_POS_RST_EN      11
`define WWG_POS_INT_EN      10
`define WWG_POS_INT_LATE    9
`define WWG_POS_RUN         8
`define WWG_POS_RST_LVAL    4
`define WWG_POS_INT_LVAL    0

// Key values, first and second write of each pair
`define WWG_KEY_FEED_A      8'ha5
`define WWG_KEY_FEED_B      8'h5a
`define WWG_KEY_START_A     8'hfe
`define WWG_KEY_START_B     8'hed
`define WWG_KEY_STOP_A      8'hde
`define WWG_KEY_STOP_B      8'had

// Reset values
`define WWG_RST_TALLY       32'h0000_0000
`define WWG_RST_CODE        4'h0
`define WWG_RST_SOURCE      3'h0
`define WWG_RST_KEY         8'h00

// Threshold code 0 means two to the power of this
`define WWG_THR_TOP_EXP     5'd31

// Tick source code that yields no ticks at all
`define WWG_SRC_NONE        3'h7

`endif

/* src/wwg_pkg.sv */
// Types shared by the windowed watchdog modules
package wwg_pkg;

    // Pending first key of a two-write sequence
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_FEED1,
        KEY_START1,
        KEY_STOP1
    } wwg_key_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wrData;
        logic        wrStb;
        logic        rdStb;
    } wwg_bus_t;

    // Whole state of the watchdog core
    typedef struct packed {
        logic [31:0] count;
        logic        rstLate;
        logic        rstEarly;
        logic        winEn;
        logic        clkRdyIe;
        logic [3:0]  rstEarlyVal;
        logic [3:0]  intEarlyVal;
        logic        intEarly;
        logic        rstEn;
        logic        intEn;
        logic        intLate;
        logic        runBit;
        logic [3:0]  rstLateVal;
        logic [3:0]  intLateVal;
        logic        runLive;
        logic        feedPend;
        wwg_key_t    keyState;
        logic [7:0]  keyLast;
        logic [2:0]  tickSel;
        logic [31:0] rdData;
        logic        sysRstReq;
    } wwg_state_t;

    // State of the tick divider
    typedef struct packed {
        logic [11:0] pre;
        logic        tick;
    } wwg_div_state_t;

endpackage

/* src/wwg_tick_divider.sv */
// Tick enable generator for the watchdog tally, rate chosen by the source select
`timescale 1ns/10ps
`default_nettype none
`include "wwg_defs.svh"

module wwg_tick_divider (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Source select
    input  wire logic [2:0] tickSel,
    // One-cycle tick enable
    output logic            tickEn
);

    // Registered state and its next copy
    wwg_pkg::wwg_div_state_t st;
    wwg_pkg::wwg_div_state_t next_st;
    // Divider mask for the chosen source
    logic [11:0]             mask;

    // Source n divides by four to the power n; the top code gives no ticks
    always_comb begin
        mask = 12'h000;
        case (tickSel)
            3'h0: mask = 12'h000;
            3'h1: mask = 12'h003;
            3'h2: mask = 12'h00f;
            3'h3: mask = 12'h03f;
            3'h4: mask = 12'h0ff;
            3'h5: mask = 12'h3ff;
            3'h6: mask = 12'hfff;
            default: mask = 12'h000;
        endcase
        // Free-running prescaler, so a source change takes effect at once
        next_st.pre  = st.pre + 12'h001;
        next_st.tick = ((st.pre & mask) == mask) && (tickSel != `WWG_SRC_NONE);
    end

    // Register the divider state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Tick comes straight from a flop
    assign tickEn = st.tick;

endmodule

`default_nettype wire

/* tb/test_windowed_watchdog_guard.sv */
// Self-checking bench for the windowed watchdog core
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module test_windowed_watchdog_guard;
    logic        mclk = 1'b0;     // Bus clock
    logic        nrst = 1'b0;     // Power-on reset
    logic        sysResetActive = 1'b0; // System reset level
    logic [7:0]  addr = 8'h00;    // Register offset
    logic [31:0] wrData = 32'h0;  // Write data
    logic        wrStb = 1'b0;    // Write strobe
    logic        rdStb = 1'b0;    // Read strobe
    logic [31:0] rdData;          // Read data
    logic        wdtIrq;          // Interrupt level
    logic        sysRstReq;       // Reset request pulse
    int          err_count = 0;   // Mismatches
    int          cmp_count = 0;   // Comparisons
    int          pulses = 0;      // Reset requests seen
    int          seed = 59;       // Random seed
    logic [31:0] v;               // Random stimulus
    logic [31:0] d;               // Read result
    logic [31:0] t1;              // Tally sample
    logic [31:0] t2;              // Tally sample

    wwg_core i_wwg_core (
        .mclk(mclk),
        .nrst(nrst),
        .sysResetActive(sysResetActive),
        .addr(addr),
        .wrData(wrData),
        .wrStb(wrStb),
        .rdStb(rdStb),
        .rdData(rdData),
        .wdtIrq(wdtIrq),
        .sysRstReq(sysRstReq)
    );

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    // Count reset request pulses
    always @(posedge mclk) begin
        if (sysRstReq === 1'b1) begin
            pulses++;
        end
    end

    // Verdict and end of run
    task automatic wrap_up();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One-cycle register write, strobe left high for back-to-back use
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        @(posedge mclk);
        addr <= a;
        wrData <= dv;
        wrStb <= 1'b1;
        rdStb <= 1'b0;
    endtask

    // Register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] dv);
        @(posedge mclk);
        addr <= a;
        wrStb <= 1'b0;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1;
        dv = rdData;
    endtask

    // Idle cycles with both strobes low
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mclk);
            wrStb <= 1'b0;
            rdStb <= 1'b0;
        end
    endtask

    // Feed pair as two consecutive writes
    task automatic feed();
        wr(8'h04, 32'ha5);
        wr(8'h04, 32'h5a);
        idle(1);
    endtask

    // Poll a control bit under a bound
    task automatic poll(input int bn, input int lim);
        int k;
        logic [31:0] p;
        k = 0;
        p = 32'h0;
        while (p[bn] !== 1'b1 && k < lim) begin
            rd(8'h00, p);
            k++;
        end
        `CHK("poll", 1'b1, p[bn])
        if (p[bn] !== 1'b1) begin
            wrap_up();
        end
    endtask

    // Hang guard
    initial begin
        repeat (95000) @(posedge mclk);
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        // Random control fields, run bit kept low; interrupt gating model
        for (int i = 0; i < 8; i++) begin
            v = $random(seed) & 32'he8ff_1eff;
            wr(8'h00, v);
            idle(1);
            #1;
            `CHK("irq", v[10] & (v[9] | v[29] & v[12]) | v[27], wdtIrq)
            rd(8'h00, d);
            `CHK("ctl", v | 32'h1000_0000, d)
        end
        // Key byte readback, unmapped write ignored and read zero
        v = $random(seed);
        wr(8'h04, v);
        rd(8'h04, d);
        `CHK("key", {24'h0, v[7:0]}, d)
        wr(8'h00, 32'h0);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h00, d);
        `CHK("ctl", 32'h1000_0000, d)
        rd(8'h10, d);
        `CHK("unmapped", 32'h0, d)
        // Wrong second key drops the pending start
        wr(8'h04, 32'hfe);
        wr(8'h04, 32'h5a);
        wr(8'h04, 32'hed);
        rd(8'h00, d);
        `CHK("run", 1'b0, d[8])
        // Window setup with flags cleared, then feed
        wr(8'h04, 32'hde);
        wr(8'h04, 32'had);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h20fe_0cef);
        feed();
        // Start pair split by a gap and another write
        wr(8'h04, 32'hfe);
        idle(5);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'hed);
        rd(8'h00, d);
        `CHK("start", 2'b01, {d[28], d[8]})
        poll(28, 20);
        rd(8'h00, d);
        `CHK("flags", 4'h0, {d[31:30], d[12], d[9]})
        // Source write refused while running
        wr(8'h08, 32'h7);
        rd(8'h08, d);
        `CHK("source", 32'h0, d)
        // Late interrupt at 2^16 ticks
        poll(9, 40000);
        rd(8'h0c, t1);
        `CHK("late", 1'b1, t1 >= 32'd65536 && t1 < 32'd65546)
        `CHK("irq", 1'b1, wdtIrq)
        `CHK("pulses", 0, pulses)
        // Feed inside the early-interrupt band
        feed();
        idle(4);
        rd(8'h00, d);
        `CHK("early", 2'b01, {d[30], d[12]})
        `CHK("pulses", 0, pulses)
        // Feed far too early
        feed();
        idle(4);
        rd(8'h00, d);
        `CHK("rstEarly", 1'b1, d[30])
        `CHK("pulses", 1, pulses)
        // System reset keeps run and flags, zeroes tally and settings
        @(posedge mclk);
        sysResetActive <= 1'b1;
        idle(4);
        sysResetActive <= 1'b0;
        rd(8'h0c, t1);
        `CHK("tally", 1'b1, t1 < 32'd16)
        rd(8'h00, d);
        `CHK("ctl", 32'h5000_1300, d)
        idle(10);
        rd(8'h0c, t2);
        `CHK("resume", 1'b1, t2 > t1)
        // Stop pair and tally hold
        wr(8'h04, 32'hde);
        wr(8'h04, 32'had);
        rd(8'h00, d);
        `CHK("stop", 1'b0, d[8])
        poll(28, 20);
        rd(8'h0c, t1);
        idle(20);
        rd(8'h0c, t2);
        `CHK("hold", t1, t2)
        // Tick source off, then a back-to-back start pair the tick side never follows
        wr(8'h08, 32'h7);
        rd(8'h08, d);
        `CHK("source", 32'h7, d)
        wr(8'h04, 32'hfe);
        wr(8'h04, 32'hed);
        rd(8'h00, d);
        `CHK("start2", 2'b01, {d[28], d[8]})
        idle(8);
        rd(8'h00, d);
        `CHK("stalled", 2'b01, {d[28], d[8]})
        rd(8'h0c, t1);
        `CHK("hold2", t2, t1)
        wrap_up();
    end
endmodule
`default_nettype wire

/* tb/wwg_core_monitor.sv */
// Port checker for the windowed watchdog core
`timescale 1ns/10ps
`default_nettype none

module wwg_core_monitor (
    // Clock and power-on reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Inputs of the core
    input wire logic        sysResetActive,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic        wrStb,
    input wire logic        rdStb,
    // Outputs of the core
    input wire logic [31:0] rdData,
    input wire logic        wdtIrq,
    input wire logic        sysRstReq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // One write of a key byte
    sequence keyWr(logic [7:0] k);
        wrStb && addr == 8'h04 && wrData[7:0] == k;
    endsequence

    // Control word read
    sequence ctlRd;
        rdStb && addr == 8'h00;
    endsequence

    // Start pair then read shows the run bit
    start_sets_run_a: assert property (keyWr(8'hfe) ##1 keyWr(8'hed) ##1 ctlRd |=> rdData[8])
        else $error("run bit not set by start pair");
    // Stop pair then read shows run cleared
    stop_clears_run_a: assert property (keyWr(8'hde) ##1 keyWr(8'had) ##1 ctlRd |=> !rdData[8])
        else $error("run bit not cleared by stop pair");
    // Read data only in the cycle after a read
    idle_read_zero_a: assert property (!$past(rdStb) |-> rdData == 32'h0)
        else $error("read data outside a read");
    // Reserved control bits read zero
    ctl_reserved_zero_a: assert property (ctlRd |=> rdData[26:24] == 3'h0 && rdData[15:13] == 3'h0)
        else $error("reserved control bits not zero");
    // Key register holds one byte
    key_byte_only_a: assert property ($past(rdStb && addr == 8'h04) |-> rdData[31:8] == 24'h0)
        else $error("key read wider than a byte");
    // Unmapped offsets read zero
    unmapped_zero_a: assert property ($past(rdStb && addr > 8'h0c) |-> rdData == 32'h0)
        else $error("unmapped read not zero");
    // Reset request is a single pulse
    rst_pulse_once_a: assert property (sysRstReq |=> !sysRstReq)
        else $error("reset request longer than one cycle");
    // System reset silences request and interrupt
    sysrst_quiet_a: assert property ($past(sysResetActive) |-> !sysRstReq && !wdtIrq)
        else $error("request or interrupt during system reset");
endmodule

bind wwg_core wwg_core_monitor i_wwg_core_monitor (
    .mclk(mclk),
    .nrst(nrst),
    .sysResetActive(sysResetActive),
    .addr(addr),
    .wrData(wrData),
    .wrStb(wrStb),
    .rdStb(rdStb),
    .rdData(rdData),
    .wdtIrq(wdtIrq),
    .sysRstReq(sysRstReq)
);
`default_nettype wire
